// file: core/mode_zero_core.sv
// Mode register zero behaviour: burst order, latency, recovery, loop reset.
// Assumes a single AHB-Lite master on hclk and one bank of recovery tracking.
//
// The implementer's own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "mode_zero_map.svh"

module mode_zero_core
   import mode_zero_pkg::*;
#(
   parameter int FIELD_W = 5
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic beat_valid,
   output logic [2:0] beat_col,
   output logic data_strobe_oe_n,
   output logic write_commit,
   output logic write_cancel,
   output logic loop_reset,
   output logic test_mode,
   output logic bank_ready
);
   localparam int REC_W = FIELD_W + 2;

   logic [31:0] mode_q, mode_d;
   logic [31:0] timing_q, timing_d;
   logic [31:0] hrdata_q, hrdata_d;
   logic wr_pend_q, wr_pend_d;
   logic [7:0] addr_q, addr_d;
   logic loop_q, loop_d;
   logic cmd_go;
   logic [31:0] status;

   seq_state_t state_q, state_d;
   logic [FIELD_W-1:0] cnt_q, cnt_d;
   logic [2:0] beat_q, beat_d;
   logic is_wr_q, is_wr_d;
   logic chop_q, chop_d;
   logic fixed_chop_q, fixed_chop_d;
   logic crc_bad_q, crc_bad_d;
   logic [2:0] start_q, start_d;
   logic ilv_q, ilv_d;
   logic [REC_W-1:0] rec_q, rec_d;
   logic cancel_q, cancel_d;
   logic bv_q, bv_d;
   logic [2:0] bcol_q, bcol_d;
   logic oe_n_q, oe_n_d;
   logic commit_q, commit_d;
   logic cpulse_q, cpulse_d;

   beat_order_if bo ();

   beat_order u_order (
      .bo(bo.orderer)
   );

   function automatic logic [FIELD_W-1:0] fld(input logic [31:0] r, input int lsb);
      fld = FIELD_W'(r >> lsb);
   endfunction : fld

   burst_length_t bl_mode;
   assign bl_mode = burst_length_t'(mode_q[`MZ_MODE_BL_LSB +: 2]);

   assign bo.start_col = start_q;
   assign bo.interleave = ilv_q;
   assign bo.beat = beat_q;

   assign cmd_go = wr_pend_q && (addr_q == `MZ_OFF_CMD) && (state_q == ST_IDLE);

   always_comb begin
      status = 32'h00000000;
      status[`MZ_ST_BUSY_BIT] = (state_q != ST_IDLE);
      status[`MZ_ST_LOOPRST_BIT] = loop_q;
      status[`MZ_ST_CANCEL_BIT] = cancel_q;
      status[`MZ_ST_TEST_BIT] = mode_q[`MZ_MODE_TEST_BIT];
      status[`MZ_ST_READY_BIT] = (rec_q == '0);
   end

   // Bus slave: address phase captured, write data taken in the data phase.
   always_comb begin
      mode_d = mode_q;
      timing_d = timing_q;
      hrdata_d = hrdata_q;
      wr_pend_d = 1'b0;
      addr_d = addr_q;
      loop_d = loop_q;
      if (loop_q) begin
         loop_d = 1'b0;
         mode_d[`MZ_MODE_LOOPRST_BIT] = 1'b0;
      end
      if (wr_pend_q) begin
         unique case (addr_q)
            `MZ_OFF_MODE: begin
               mode_d = hwdata;
               loop_d = hwdata[`MZ_MODE_LOOPRST_BIT];
            end
            `MZ_OFF_TIMING: begin
               timing_d = hwdata;
            end
            default: begin
            end
         endcase
      end
      if (hsel && hready && htrans[1]) begin
         wr_pend_d = hwrite;
         addr_d = haddr;
         unique case (haddr)
            `MZ_OFF_MODE: hrdata_d = mode_d;
            `MZ_OFF_TIMING: hrdata_d = timing_d;
            `MZ_OFF_STATUS: hrdata_d = status;
            default: hrdata_d = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_q <= `MZ_MODE_RESET;
         timing_q <= `MZ_TIMING_RESET;
         hrdata_q <= 32'h00000000;
         wr_pend_q <= 1'b0;
         addr_q <= 8'h00;
         loop_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         timing_q <= timing_d;
         hrdata_q <= hrdata_d;
         wr_pend_q <= wr_pend_d;
         addr_q <= addr_d;
         loop_q <= loop_d;
      end
   end

   // Command sequencer: hold, latency, eight beat slots, recovery.
   always_comb begin
      logic chk_on;
      logic [REC_W-1:0] precharge_time;
      logic [REC_W-1:0] extra;
      logic [2:0] wr_start_beat;
      chk_on = timing_q[`MZ_TIM_DM_BIT] && timing_q[`MZ_TIM_CRC_BIT];
      precharge_time = REC_W'(fld(timing_q, `MZ_TIM_TRP_LSB));
      extra = chk_on ? REC_W'(fld(timing_q, `MZ_TIM_CRCX_LSB)) : '0;
      // Fixed chop starts the internal write two clocks early.
      wr_start_beat = fixed_chop_q ? `MZ_BEAT_LAST - `MZ_CHOP_EARLY : `MZ_BEAT_LAST;
      state_d = state_q;
      cnt_d = cnt_q;
      beat_d = beat_q;
      is_wr_d = is_wr_q;
      chop_d = chop_q;
      fixed_chop_d = fixed_chop_q;
      crc_bad_d = crc_bad_q;
      start_d = start_q;
      ilv_d = ilv_q;
      rec_d = (rec_q != '0) ? rec_q - 1'b1 : rec_q;
      cancel_d = cancel_q;
      bv_d = 1'b0;
      bcol_d = bcol_q;
      oe_n_d = 1'b1;
      commit_d = 1'b0;
      cpulse_d = 1'b0;
      unique case (state_q)
         ST_IDLE: begin
            if (cmd_go) begin
               is_wr_d = hwdata[`MZ_CMD_WRITE_BIT];
               chop_d = (bl_mode == BL_FIXED_CHOP) ||
                  ((bl_mode == BL_ON_THE_FLY) && hwdata[`MZ_CMD_CHOP_BIT]);
               fixed_chop_d = (bl_mode == BL_FIXED_CHOP);
               ilv_d = mode_q[`MZ_MODE_TYPE_BIT];
               crc_bad_d = chk_on && !hwdata[`MZ_CMD_CRCOK_BIT];
               start_d = hwdata[`MZ_CMD_COL_LSB +: 3];
               if (hwdata[`MZ_CMD_WRITE_BIT]) begin
                  start_d = chop_d ? {hwdata[`MZ_CMD_COL_LSB + 2], 2'b00} : 3'b000;
               end
               beat_d = 3'b000;
               cnt_d = fld(mode_q, `MZ_MODE_AL_LSB);
               state_d = (cnt_d == '0) ? ST_LAT : ST_HOLD;
               if (cnt_d == '0) begin
                  cnt_d = fld(mode_q, `MZ_MODE_CL_LSB);
               end
            end
         end
         ST_HOLD: begin
            cnt_d = cnt_q - 1'b1;
            if (cnt_q <= FIELD_W'(1)) begin
               cnt_d = fld(mode_q, `MZ_MODE_CL_LSB);
               state_d = ST_LAT;
            end
         end
         ST_LAT: begin
            if (!is_wr_q && (cnt_q == fld(mode_q, `MZ_MODE_CL_LSB))) begin
               rec_d = REC_W'(fld(mode_q, `MZ_MODE_RTP_LSB)) + precharge_time;
            end
            cnt_d = cnt_q - 1'b1;
            if (cnt_q <= FIELD_W'(1)) begin
               state_d = ST_BURST;
            end
         end
         ST_BURST: begin
            // First beat after added plus column latency.
            bcol_d = bo.col;
            bv_d = !(chop_q && (beat_q >= `MZ_BEAT_HALF));
            oe_n_d = is_wr_q || (chop_q && (beat_q >= `MZ_BEAT_HALF));
            if (is_wr_q && (beat_q == wr_start_beat)) begin
               if (crc_bad_q) begin
                  cancel_d = 1'b1;
                  cpulse_d = 1'b1;
               end else begin
                  commit_d = 1'b1;
               end
               rec_d = REC_W'(fld(mode_q, `MZ_MODE_WR_LSB)) + precharge_time + extra;
            end
            beat_d = beat_q + 1'b1;
            if (beat_q == `MZ_BEAT_LAST) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
      if (wr_pend_q && (addr_q == `MZ_OFF_STATUS) && hwdata[`MZ_ST_CANCEL_BIT] && !cpulse_d) begin
         cancel_d = 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= ST_IDLE;
         cnt_q <= '0;
         beat_q <= 3'b000;
         is_wr_q <= 1'b0;
         chop_q <= 1'b0;
         fixed_chop_q <= 1'b0;
         crc_bad_q <= 1'b0;
         start_q <= 3'b000;
         ilv_q <= 1'b0;
         rec_q <= '0;
         cancel_q <= 1'b0;
         bv_q <= 1'b0;
         bcol_q <= 3'b000;
         oe_n_q <= 1'b1;
         commit_q <= 1'b0;
         cpulse_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         beat_q <= beat_d;
         is_wr_q <= is_wr_d;
         chop_q <= chop_d;
         fixed_chop_q <= fixed_chop_d;
         crc_bad_q <= crc_bad_d;
         start_q <= start_d;
         ilv_q <= ilv_d;
         rec_q <= rec_d;
         cancel_q <= cancel_d;
         bv_q <= bv_d;
         bcol_q <= bcol_d;
         oe_n_q <= oe_n_d;
         commit_q <= commit_d;
         cpulse_q <= cpulse_d;
      end
   end

   logic ready_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ready_q <= 1'b0;
      end else begin
         ready_q <= (rec_d == '0);
      end
   end

   logic hro_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hro_q <= 1'b1;
      end else begin
         hro_q <= 1'b1;
      end
   end

   assign hrdata = hrdata_q;
   assign hreadyout = hro_q;
   assign hresp = 1'b0 & hro_q;
   assign beat_valid = bv_q;
   assign beat_col = bcol_q;
   assign data_strobe_oe_n = oe_n_q;
   assign write_commit = commit_q;
   assign write_cancel = cpulse_q;
   assign loop_reset = loop_q;
   assign test_mode = mode_q[`MZ_MODE_TEST_BIT];
   assign bank_ready = ready_q;
endmodule : mode_zero_core
`default_nettype wire

// file: core/mode_zero_map.svh
// Register offsets, field positions and reset values of the mode zero block.
// Assumes word-aligned AHB-Lite access with 32-bit data.
`ifndef MODE_ZERO_MAP_SVH
`define MODE_ZERO_MAP_SVH
`define MZ_OFF_MODE 8'h00
`define MZ_OFF_TIMING 8'h04
`define MZ_OFF_CMD 8'h08
`define MZ_OFF_STATUS 8'h0c
`define MZ_MODE_BL_LSB 0
`define MZ_MODE_TYPE_BIT 3
`define MZ_MODE_TEST_BIT 7
`define MZ_MODE_LOOPRST_BIT 8
`define MZ_MODE_WR_LSB 9
`define MZ_MODE_RTP_LSB 14
`define MZ_MODE_CL_LSB 19
`define MZ_MODE_AL_LSB 24
`define MZ_TIM_TRP_LSB 0
`define MZ_TIM_CRCX_LSB 5
`define MZ_TIM_DM_BIT 16
`define MZ_TIM_CRC_BIT 17
`define MZ_CMD_WRITE_BIT 0
`define MZ_CMD_CHOP_BIT 1
`define MZ_CMD_COL_LSB 2
`define MZ_CMD_CRCOK_BIT 5
`define MZ_ST_BUSY_BIT 0
`define MZ_ST_LOOPRST_BIT 1
`define MZ_ST_CANCEL_BIT 2
`define MZ_ST_TEST_BIT 3
`define MZ_ST_READY_BIT 4
`define MZ_MODE_RESET 32'h00000000
`define MZ_TIMING_RESET 32'h00000000
`define MZ_BEAT_LAST 3'h7
`define MZ_BEAT_HALF 3'h4
`define MZ_CHOP_EARLY 3'h2
`endif

// file: core/mode_zero_pkg.sv
// Types shared by the mode zero block and its beat order helper.
// Assumes nothing of its surroundings.
package mode_zero_pkg;
   typedef enum logic [1:0] {
      BL_FIXED_EIGHT = 2'h0,
      BL_ON_THE_FLY = 2'h1,
      BL_FIXED_CHOP = 2'h2,
      BL_RESERVED = 2'h3
   } burst_length_t;
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_HOLD = 5'h02,
      ST_LAT = 5'h04,
      ST_BURST = 5'h08,
      ST_SPARE = 5'h10
   } seq_state_t;
endpackage : mode_zero_pkg

// file: core/beat_order_if.sv
// Carries a burst start column and beat number to the order helper.
// Assumes one clock domain; the helper answers combinationally.
`timescale 1ns/1ps
`default_nettype none
interface beat_order_if;
   logic [2:0] start_col;
   logic interleave;
   logic [2:0] beat;
   logic [2:0] col;
   modport requester (output start_col, output interleave, output beat, input col);
   modport orderer (input start_col, input interleave, input beat, output col);
endinterface : beat_order_if
`default_nettype wire

// file: core/beat_order.sv
// Column index of one beat inside an eight-beat burst.
// Assumes a start column already masked for writes.
`timescale 1ns/1ps
`default_nettype none
module beat_order
   import mode_zero_pkg::*;
(
   beat_order_if.orderer bo
);
   always_comb begin
      if (bo.interleave) begin
         bo.col = bo.start_col ^ bo.beat;
      end else begin
         bo.col = {bo.start_col[2] ^ bo.beat[2], 2'(bo.start_col[1:0] + bo.beat[1:0])};
      end
   end
endmodule : beat_order
`default_nettype wire

// file: bench/mode_zero_core_asserts.sv
// Checker for the mode zero core, bound to its top-level ports.
// Assumes one clock and the active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
`include "mode_zero_map.svh"
module mode_zero_core_asserts (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic beat_valid,
   input wire logic data_strobe_oe_n,
   input wire logic write_commit,
   input wire logic write_cancel,
   input wire logic loop_reset,
   input wire logic test_mode
);
   logic wm_q, done_q, bit7_q;
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wm_q <= 1'b0;
         done_q <= 1'b0;
         bit7_q <= 1'b0;
      end else begin
         wm_q <= hsel && hready && htrans[1] && hwrite && haddr == `MZ_OFF_MODE;
         done_q <= wm_q;
         if (wm_q) begin
            bit7_q <= hwdata[`MZ_MODE_TEST_BIT];
         end
      end
   end
   property p_loop_cause;
      wm_q && hwdata[`MZ_MODE_LOOPRST_BIT] |-> ##[1:2] loop_reset;
   endproperty
   a_loop_cause: assert property (p_loop_cause) else $error("loop reset missing");
   property p_loop_pulse;
      loop_reset |=> !loop_reset;
   endproperty
   a_loop_pulse: assert property (p_loop_pulse) else $error("loop reset too long");
   property p_test_bit;
      done_q |-> ##[0:1] test_mode == bit7_q;
   endproperty
   a_test_bit: assert property (p_test_bit) else $error("test mode not applied");
   property p_cancel_excl;
      write_cancel |-> !write_commit;
   endproperty
   a_cancel_excl: assert property (p_cancel_excl) else $error("cancel with commit");
   property p_pulse_once;
      write_commit || write_cancel |=> !(write_commit || write_cancel);
   endproperty
   a_pulse_once: assert property (p_pulse_once) else $error("write pulse too long");
   property p_burst_max;
      beat_valid [*8] |=> !beat_valid;
   endproperty
   a_burst_max: assert property (p_burst_max) else $error("burst over eight");
   property p_oe_min;
      $fell(data_strobe_oe_n) |-> !data_strobe_oe_n [*4];
   endproperty
   a_oe_min: assert property (p_oe_min) else $error("read drive too short");
   property p_oe_write;
      write_commit |-> data_strobe_oe_n;
   endproperty
   a_oe_write: assert property (p_oe_write) else $error("driving during write");
   c_loop: cover property (loop_reset);
   c_cancel: cover property (write_cancel);
   c_read: cover property ($fell(data_strobe_oe_n));
endmodule : mode_zero_core_asserts
bind mode_zero_core mode_zero_core_asserts i_chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
   .hwrite, .hwdata, .hready, .beat_valid, .data_strobe_oe_n, .write_commit, .write_cancel,
   .loop_reset, .test_mode);
`default_nettype wire

// file: bench/ctrl_model.sv
// Controller model: single-word AHB-Lite transfers and the lock wait.
// Assumes one slave whose hreadyout is fed back as hready.
`timescale 1ns/1ps
`default_nettype none
module ctrl_model #(
   parameter int LOCK_CYC = 16
) (
   input wire logic hclk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   output logic hsel,
   output logic [7:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   initial begin
      hsel = 1'b0;
      haddr = 8'h00;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      haddr <= ~a;
      htrans <= 2'h0;
      hwdata <= w ? d : ~hwdata;
      do @(posedge hclk); while (hready !== 1'b1);
      r = hrdata;
   endtask : xfer
   task automatic lock_wait();
      repeat (LOCK_CYC) @(posedge hclk);
   endtask : lock_wait
endmodule : ctrl_model
`default_nettype wire

// file: bench/test_mode_zero_core.sv
// Self-checking bench for the mode zero core: beat order, latency, recovery.
// Assumes the controller model drives the core's hsel, haddr, htrans, hwrite, hsize and hwdata; hready is fed from the core's own hreadyout.
`timescale 1ns/1ps
`default_nettype none
`include "mode_zero_map.svh"
module test_mode_zero_core
   import mode_zero_pkg::*;
;
   typedef struct packed {
      logic [3:0] bl, ch, wr, il, al, cl, read_to_precharge_setting, ok, nb, cg;
   } row_t;
   localparam logic [4:0] WRV = 5'h4;
   // Precharge time and checksum extra recovery of the timing word.
   localparam int TRPV = 3;
   localparam int CRCX = 6;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel, hwrite, hreadyout, hresp, beat_valid, data_strobe_oe_n;
   logic write_commit, write_cancel, loop_reset, test_mode, bank_ready;
   logic [7:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize, beat_col, sc;
   logic [31:0] hwdata, hrdata, q;
   int num_errors = 0, samples_checked = 0, cyc = 0;
   int nv, oe, rc, cm, cn, lp, t0, t1, tc;
   row_t cur;
   // Fields: length, chop, write, interleave, added, column, rtp, crc ok, beats, commit gap.
   row_t rows [10] = '{40'h0000042180, 40'h0001342180, 40'h2000065140, 40'h2101042140,
      40'h1101042140, 40'h1000252180, 40'h0010042187, 40'h2011042145, 40'h1110042147,
      40'h1011042087};
   always #12.5 hclk = ~hclk;
   ctrl_model i_ctl (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata);
   mode_zero_core i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .beat_valid, .beat_col,
      .data_strobe_oe_n, .write_commit, .write_cancel, .loop_reset, .test_mode, .bank_ready);
   task complete_run;
      if (num_errors == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : complete_run
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   function automatic logic [2:0] ecol(row_t r, logic [2:0] s, logic [2:0] n);
      logic c;
      c = r.bl[1:0] == BL_FIXED_CHOP || (r.bl[1:0] == BL_ON_THE_FLY && r.ch[0]);
      if (r.wr[0]) s = c ? {s[2], 2'h0} : 3'h0;
      return r.il[0] ? s ^ n : {s[2] ^ n[2], s[1:0] + n[1:0]};
   endfunction : ecol
   function automatic logic [31:0] mode_of(row_t r);
      return {4'h0, r.al, 1'h0, r.cl, 1'h0, r.read_to_precharge_setting, WRV, 5'h0, r.il[0], 1'h0, r.bl[1:0]};
   endfunction : mode_of
   always @(negedge hclk) begin
      if (beat_valid === 1'b1) begin
         if (nv == 0) t0 = cyc;
         chk(beat_col, ecol(cur, sc, nv[2:0]));
         nv++;
      end
      oe += data_strobe_oe_n === 1'b0;
      rc += bank_ready === 1'b0;
      lp += loop_reset === 1'b1;
      cm += write_commit === 1'b1;
      cn += write_cancel === 1'b1;
      if (write_commit === 1'b1 || write_cancel === 1'b1) t1 = cyc;
   end
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         num_errors++;
         complete_run();
      end
   end
   task automatic burst(input row_t r, input logic [2:0] s);
      cur = r;
      sc = s;
      {nv, oe, rc, cm, cn} = '0;
      i_ctl.xfer(`MZ_OFF_CMD, 1'b1, {26'h0, r.ok[0], s, r.ch[0], r.wr[0]}, q);
      tc = cyc;
      i_ctl.xfer(`MZ_OFF_CMD, 1'b1, 32'h0000003f, q);
      repeat (90) @(negedge hclk);
      chk(nv, r.nb);
      chk(oe, r.wr[0] ? 0 : r.nb);
      // Both mask and checksum are on, so every write takes the extra recovery.
      chk(rc, r.wr[0] ? WRV + TRPV + CRCX : r.read_to_precharge_setting + TRPV);
      if (r.wr[0]) begin
         chk(t1 - t0, r.cg);
         chk(cm, r.ok[0]);
         chk(cn, !r.ok[0]);
      end else begin
         // First beat shows one edge after the latency; tc is read before its edge.
         chk(t0 - tc, r.al + r.cl + 2);
      end
   endtask : burst
   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      i_ctl.xfer(`MZ_OFF_TIMING, 1'b1, {14'h0, 2'h3, 6'h0, 5'(CRCX), 5'(TRPV)}, q);
      for (int i = 0; i < 10; i++) begin
         i_ctl.xfer(`MZ_OFF_MODE, 1'b1, mode_of(rows[i]), q);
         for (int s = 0; s < 8; s++) begin
            burst(rows[i], 3'(s));
         end
      end
      i_ctl.xfer(`MZ_OFF_STATUS, 1'b0, 32'h0, q);
      chk(q[`MZ_ST_CANCEL_BIT], 1'b1);
      i_ctl.xfer(`MZ_OFF_STATUS, 1'b1, 32'h00000004, q);
      i_ctl.xfer(`MZ_OFF_STATUS, 1'b0, 32'h0, q);
      chk(q[`MZ_ST_CANCEL_BIT], 1'b0);
      lp = 0;
      i_ctl.xfer(`MZ_OFF_MODE, 1'b1, 32'h00000180, q);
      i_ctl.lock_wait();
      chk(lp, 1);
      chk(test_mode, 1'b1);
      i_ctl.xfer(`MZ_OFF_MODE, 1'b0, 32'h0, q);
      chk(q, 32'h00000080);
      i_ctl.xfer(`MZ_OFF_MODE, 1'b1, 32'h0, q);
      repeat (2) @(negedge hclk);
      chk(test_mode, 1'b0);
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (20) @(posedge hclk);
      chk({hreadyout, hresp, data_strobe_oe_n, bank_ready, test_mode}, 5'h14);
      hresetn <= 1'b1;
      i_ctl.xfer(`MZ_OFF_MODE, 1'b0, 32'h0, q);
      chk(q, `MZ_MODE_RESET);
      i_ctl.xfer(8'h10, 1'b0, 32'h0, q);
      chk(q, 32'h0);
      complete_run();
   end
endmodule : test_mode_zero_core
`default_nettype wire
